// ### hw/event_counter.sv
/*
  One 32-bit event counter: adds the occurrences of the selected event.
  Assumes event counts arrive on the same clock, packed per event.
*/
`default_nettype none
module event_counter #(
    parameter int CNT_W = 32,
    parameter int SEL_W = 5,
    parameter int OCC_W = 2
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [(2**SEL_W)*OCC_W-1:0] events_i,
    input wire logic [SEL_W-1:0] sel_i,
    input wire logic count_en_i,
    input wire logic load_i,
    input wire logic [CNT_W-1:0] load_data_i,
    output logic [CNT_W-1:0] count_o
);
    typedef struct packed {
        logic [CNT_W-1:0] count;
    } counter_state_t;

    counter_state_t state;
    counter_state_t next_state;
    logic [OCC_W-1:0] occ;

    // Load beats counting in the same cycle
    always_comb
    begin
        occ = events_i[sel_i*OCC_W +: OCC_W];
        next_state = state;
        if (load_i)
            next_state.count = load_data_i;
        else if (count_en_i)
            next_state.count = state.count + CNT_W'(occ);
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            state <= '0;
        else
            state <= next_state;
    end

    assign count_o = state.count;

endmodule
`default_nettype wire

// ### hw/perf_monitor_count_control.sv
/*
  Performance-monitor control: mode register, state-qualified counting,
  two event counters, time-base and negative-counter interrupt.
  Assumes the core checks privilege for the register moves and drives
  event counts, time base and machine state on this clock.
*/
`default_nettype none
`include "perf_monitor_regs.svh"

// Overview of operation
// - Two-bit selector picks time-base bit 63, 55, 51 or 47.
// - Enabled rise of the picked time-base bit signals an interrupt.
// - Only software writes change the time-base interrupt enable.
// - Miss threshold is six bits holding any value 0 to 63.
// - First counter negative raises interrupt only when its enable is set.
// - Second counter negative enable gates interrupt and overrides freeze.
// - Trigger hold stops second counter until first is negative or interrupt.
// - First event selector is seven bits wide.
// - Second event selector is six bits wide.
// - Marked-task flag of machine state qualifies counting.
// - Count only when privilege and marking match the configured state.
// - Four qualified states from supervisor or user, marked or unmarked.
// - Halt bits only block counting and never clear counts.
// - Halt-all bit stops counting in every state.
// - Exactly two event counters.
// - Counters clear at reset and load by register moves.
// - Counter sign bit set flags an interrupt condition.
// - Signalled interrupt clears the global interrupt enable.
// - Freeze bit stops first counter, and second without trigger hold or its negative enable.
// - Halt bits block counting in supervisor, user, marked, unmarked.
module perf_monitor_count_control #(
    parameter int OCC_W = 2
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire perf_monitor_pkg::spr_req_t spr_req_i,
    input wire perf_monitor_pkg::machine_state_reg_t machine_state_reg_i,
    input wire logic [63:0] timebase_i,
    input wire logic [(2**`EVENT_SEL_USED_BITS)*OCC_W-1:0] first_events_i,
    input wire logic [(2**`EVENT_SEL_USED_BITS)*OCC_W-1:0] second_events_i,
    output logic pm_irq_o,
    output logic spr_rd_valid_o,
    output logic [31:0] spr_rd_data_o,
    output logic [5:0] miss_threshold_o,
    output logic [31:0] first_event_counter_o,
    output logic [31:0] second_event_counter_o
);
    perf_monitor_pkg::control_state_t state;
    perf_monitor_pkg::control_state_t next_state;
    perf_monitor_pkg::monitor_mode_control_t ctl;

    logic tb_edge;
    logic [31:0] first_event_counter;
    logic [31:0] second_event_counter;
    logic first_negative;
    logic second_negative;
    logic wr_ctl;
    logic wr_first;
    logic wr_second;
    logic pmi;
    logic count_ok;
    logic freeze_now;
    logic first_en;
    logic second_en;
    logic second_free;

    // Register decode shared by read and write paths
    function automatic logic spr_hit(input logic [9:0] num, input logic [9:0] target);
        spr_hit = (num == target);
    endfunction

    assign ctl = state.ctl;

    // Move-to decode
    assign wr_ctl = spr_req_i.wr & spr_hit(spr_req_i.num, `SPR_MODE_CONTROL);
    assign wr_first = spr_req_i.wr & spr_hit(spr_req_i.num, `SPR_FIRST_COUNTER);
    assign wr_second = spr_req_i.wr & spr_hit(spr_req_i.num, `SPR_SECOND_COUNTER);

    assign first_negative = first_event_counter[`COUNTER_SIGN_BIT];
    assign second_negative = second_event_counter[`COUNTER_SIGN_BIT];

    assign pmi = ctl.irq_global_enable &
                 ((ctl.first_negative_irq_en & first_negative) |
                  (ctl.second_negative_irq_en & second_negative) |
                  (ctl.timebase_edge_irq_en & tb_edge));

    assign count_ok = ~ctl.halt_all_counting &
                      ~(ctl.halt_in_supervisor & ~machine_state_reg_i.user_mode_flag) &
                      ~(ctl.halt_in_user & machine_state_reg_i.user_mode_flag) &
                      ~(ctl.halt_when_marked & machine_state_reg_i.marked_task_flag) &
                      ~(ctl.halt_when_unmarked & ~machine_state_reg_i.marked_task_flag);

    // freeze from signalling
    // Freeze takes hold in the very cycle the interrupt is raised
    assign freeze_now = state.frozen | (pmi & ctl.freeze_on_irq);

    assign second_free = ~ctl.second_trigger_hold | state.second_armed |
                         first_negative | pmi;

    assign first_en = count_ok & ~freeze_now;
    assign second_en = count_ok & second_free &
                       ~(freeze_now & ~ctl.second_trigger_hold &
                         ~ctl.second_negative_irq_en);

    // Control state update
    always_comb
    begin
        next_state = state;
        next_state.irq = pmi;
        next_state.rd_valid = spr_req_i.rd;
        if (pmi & ctl.freeze_on_irq)
            next_state.frozen = 1'b1;
        if (ctl.second_trigger_hold & (first_negative | pmi))
            next_state.second_armed = 1'b1;
        if (pmi)
            next_state.ctl.irq_global_enable = 1'b0;
        // full six-bit threshold
        // Software write wins, so a re-arm in the interrupt cycle is kept
        if (wr_ctl)
        begin
            next_state.ctl = perf_monitor_pkg::monitor_mode_control_t'(spr_req_i.data);
            next_state.frozen = 1'b0;
            next_state.second_armed = 1'b0;
        end
        // Unmapped numbers read as zero
        if (spr_hit(spr_req_i.num, `SPR_MODE_CONTROL))
            next_state.rd_data = ctl;
        else if (spr_hit(spr_req_i.num, `SPR_FIRST_COUNTER))
            next_state.rd_data = first_event_counter;
        else if (spr_hit(spr_req_i.num, `SPR_SECOND_COUNTER))
            next_state.rd_data = second_event_counter;
        else
            next_state.rd_data = 32'h0000_0000;
        if (~spr_req_i.rd)
            next_state.rd_data = state.rd_data;
    end

    // Control register cleared at reset
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= '0;
            state.ctl <= perf_monitor_pkg::monitor_mode_control_t'(`MODE_CONTROL_RESET);
        end
        else
        begin
            state <= next_state;
        end
    end

    assign pm_irq_o = state.irq;
    assign spr_rd_valid_o = state.rd_valid;
    assign spr_rd_data_o = state.rd_data;
    assign miss_threshold_o = state.ctl.miss_threshold;
    assign first_event_counter_o = first_event_counter;
    assign second_event_counter_o = second_event_counter;

    timebase_edge_detect u_tb_edge (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .timebase_i(timebase_i),
        .sel_i(ctl.timebase_bit_select),
        .edge_o(tb_edge)
    );

    event_counter #(
        .CNT_W(32),
        .SEL_W(`EVENT_SEL_USED_BITS),
        .OCC_W(OCC_W)
    ) u_first (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .events_i(first_events_i),
        .sel_i(ctl.first_event_select[`EVENT_SEL_USED_BITS-1:0]),
        .count_en_i(first_en),
        .load_i(wr_first),
        .load_data_i(spr_req_i.data),
        .count_o(first_event_counter)
    );

    event_counter #(
        .CNT_W(32),
        .SEL_W(`EVENT_SEL_USED_BITS),
        .OCC_W(OCC_W)
    ) u_second (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .events_i(second_events_i),
        .sel_i(ctl.second_event_select[`EVENT_SEL_USED_BITS-1:0]),
        .count_en_i(second_en),
        .load_i(wr_second),
        .load_data_i(spr_req_i.data),
        .count_o(second_event_counter)
    );

    property p_tb_irq;
        @(posedge sys_clk_i) disable iff (rst_i)
        (tb_edge && ctl.timebase_edge_irq_en && ctl.irq_global_enable) |=> pm_irq_o;
    endproperty
    a_tb_irq: assert property (p_tb_irq) else $error("time-base rise lost");

    property p_irq_cause;
        @(posedge sys_clk_i) disable iff (rst_i)
        pm_irq_o |-> $past(ctl.irq_global_enable) &&
            (($past(tb_edge) && $past(ctl.timebase_edge_irq_en)) ||
             ($past(first_negative) && $past(ctl.first_negative_irq_en)) ||
             ($past(second_negative) && $past(ctl.second_negative_irq_en)));
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");

    property p_tb_en_sw_only;
        @(posedge sys_clk_i) disable iff (rst_i)
        !$past(wr_ctl) |-> $stable(ctl.timebase_edge_irq_en);
    endproperty
    a_tb_en_sw_only: assert property (p_tb_en_sw_only) else $error("enable moved by hw");

    property p_enable_cleared;
        @(posedge sys_clk_i) disable iff (rst_i)
        (pm_irq_o && !$past(wr_ctl)) |-> !ctl.irq_global_enable;
    endproperty
    a_enable_cleared: assert property (p_enable_cleared) else $error("enable not cleared");

    property p_first_neg_irq;
        @(posedge sys_clk_i) disable iff (rst_i)
        (first_negative && ctl.first_negative_irq_en && ctl.irq_global_enable) |=> pm_irq_o;
    endproperty
    a_first_neg_irq: assert property (p_first_neg_irq) else $error("negative not signalled");

    property p_halt_all;
        @(posedge sys_clk_i) disable iff (rst_i)
        (ctl.halt_all_counting && !wr_first && !wr_second) |=>
            ($stable(first_event_counter) && $stable(second_event_counter));
    endproperty
    a_halt_all: assert property (p_halt_all) else $error("counted while halted");

    property p_trigger_hold;
        @(posedge sys_clk_i) disable iff (rst_i)
        (ctl.second_trigger_hold && !state.second_armed && !first_negative &&
         !pmi && !wr_second) |=> $stable(second_event_counter);
    endproperty
    a_trigger_hold: assert property (p_trigger_hold) else $error("second ran on hold");

    property p_frozen;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state.frozen && !wr_first) |=> $stable(first_event_counter);
    endproperty
    a_frozen: assert property (p_frozen) else $error("first ran while frozen");

    property p_user_halt;
        @(posedge sys_clk_i) disable iff (rst_i)
        (ctl.halt_in_user && machine_state_reg_i.user_mode_flag && !wr_first) |=>
            $stable(first_event_counter);
    endproperty
    a_user_halt: assert property (p_user_halt) else $error("counted in user state");

endmodule
`default_nettype wire

// ### hw/perf_monitor_pkg.sv
/*
  Types shared by the performance-monitor control block.
  Assumes perf_monitor_regs.svh is compiled alongside.
*/
`default_nettype none
package perf_monitor_pkg;

    // Control register, big-endian bit 0 first (top of the word)
    typedef struct packed {
        logic halt_all_counting;
        logic halt_in_supervisor;
        logic halt_in_user;
        logic halt_when_marked;
        logic halt_when_unmarked;
        logic irq_global_enable;
        logic freeze_on_irq;
        logic [1:0] timebase_bit_select;
        logic timebase_edge_irq_en;
        logic [5:0] miss_threshold;
        logic first_negative_irq_en;
        logic second_negative_irq_en;
        logic second_trigger_hold;
        logic [6:0] first_event_select;
        logic [5:0] second_event_select;
    } monitor_mode_control_t;

    // Special-register move request from the core
    typedef struct packed {
        logic rd;
        logic wr;
        logic [9:0] num;
        logic [31:0] data;
    } spr_req_t;

    // Privilege and marking bits of the machine state register
    typedef struct packed {
        logic user_mode_flag;
        logic marked_task_flag;
    } machine_state_reg_t;

    // Control block state
    typedef struct packed {
        monitor_mode_control_t ctl;
        logic frozen;
        logic second_armed;
        logic irq;
        logic rd_valid;
        logic [31:0] rd_data;
    } control_state_t;

endpackage
`default_nettype wire

// ### hw/perf_monitor_regs.svh
/*
  Offsets, field positions, reset values and fixed bit picks of the
  performance-monitor control block, as text macros.
  Assumes the includer is compiled after this guard is seen once.
*/
`ifndef PERF_MONITOR_REGS_SVH
`define PERF_MONITOR_REGS_SVH

// Special-register numbers reached by the move instructions
`define SPR_MODE_CONTROL 10'h3b8
`define SPR_FIRST_COUNTER 10'h3c0
`define SPR_SECOND_COUNTER 10'h3c1

// Reset values
`define MODE_CONTROL_RESET 32'h0000_0000
`define COUNTER_RESET 32'h0000_0000

// Sign bit of a counter, little-endian index of big-endian bit 0
`define COUNTER_SIGN_BIT 31

// Time-base bits picked by the four selector codes, big-endian numbering
`define TB_PICK_CODE0 63
`define TB_PICK_CODE1 55
`define TB_PICK_CODE2 51
`define TB_PICK_CODE3 47
`define TB_MSB_NUMBER 63

// Selector bits actually used to pick an event
`define EVENT_SEL_USED_BITS 5

`endif

// ### hw/timebase_edge_detect.sv
/*
  Picks one time-base bit and flags its zero-to-one change.
  Assumes the time base runs on the same clock as this block.
*/
`default_nettype none
`include "perf_monitor_regs.svh"
module timebase_edge_detect (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [63:0] timebase_i,
    input wire logic [1:0] sel_i,
    output logic edge_o
);
    typedef struct packed {
        logic prev;
        logic rise;
    } edge_state_t;

    edge_state_t state;
    edge_state_t next_state;
    logic [5:0] idx;
    logic bit_now;

    always_comb
    begin
        case (sel_i)
            2'h0: idx = 6'(`TB_MSB_NUMBER - `TB_PICK_CODE0);
            2'h1: idx = 6'(`TB_MSB_NUMBER - `TB_PICK_CODE1);
            2'h2: idx = 6'(`TB_MSB_NUMBER - `TB_PICK_CODE2);
            default: idx = 6'(`TB_MSB_NUMBER - `TB_PICK_CODE3);
        endcase
        bit_now = timebase_i[idx];
        next_state.prev = bit_now;
        next_state.rise = bit_now & ~state.prev;
    end

    // A change of selector may show one false rise
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            state <= '0;
        else
            state <= next_state;
    end

    assign edge_o = state.rise;

    property p_edge_on_rise;
        @(posedge sys_clk_i) disable iff (rst_i)
        ($rose(bit_now) && $stable(sel_i)) |=> edge_o;
    endproperty
    a_edge_on_rise: assert property (p_edge_on_rise) else $error("rise not flagged");

    property p_edge_cause;
        @(posedge sys_clk_i) disable iff (rst_i)
        edge_o |-> $past(bit_now) && !$past(state.prev);
    endproperty
    a_edge_cause: assert property (p_edge_cause) else $error("edge without rise");

endmodule
`default_nettype wire

// ### tb/core_event_source.sv
/*
  Behavioural model of the core side: event occurrence counts and the
  privilege and marking bits of the machine state.
  Assumes the bench changes its controls at the falling clock edge.
*/
`default_nettype none
module core_event_source (
    input wire logic [4:0] sel_i,
    input wire logic [1:0] occ_i,
    input wire logic run_i,
    input wire logic user_i,
    input wire logic marked_i,
    output logic [63:0] events_o,
    output var perf_monitor_pkg::machine_state_reg_t state_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // One chosen event reports, the rest stay silent to expose bad selects
    assign events_o = run_i ? ({62'h0, occ_i} << {sel_i, 1'b0}) : 64'h0;

    assign state_o = perf_monitor_pkg::machine_state_reg_t'({user_i, marked_i});
endmodule
`default_nettype wire

// ### tb/perf_monitor_count_control_tb_top.sv
/*
  Self-checking bench of the performance-monitor control block.
  Assumes the core-side model in core_event_source and design files.
*/
`default_nettype none
module perf_monitor_count_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    perf_monitor_pkg::spr_req_t req = '0;
    perf_monitor_pkg::machine_state_reg_t ms;
    logic [63:0] tb = 64'h0;
    logic [63:0] ev;
    logic [4:0] ev_sel = 5'h0;
    logic [1:0] occ = 2'h0;
    logic run = 1'b0;
    logic user = 1'b0;
    logic marked = 1'b0;
    logic irq;
    logic rd_valid;
    logic [31:0] rd_data;
    logic [31:0] cnt1;
    logic [31:0] cnt2;
    logic [5:0] thr;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int n_irq = 0;

    always #2.5 sys_clk = ~sys_clk;

    core_event_source i_core_event_source (.sel_i(ev_sel), .occ_i(occ), .run_i(run),
        .user_i(user), .marked_i(marked), .events_o(ev), .state_o(ms));

    perf_monitor_count_control i_perf_monitor_count_control (.sys_clk_i(sys_clk),
        .rst_i(rst), .spr_req_i(req), .machine_state_reg_i(ms), .timebase_i(tb),
        .first_events_i(ev), .second_events_i(ev), .pm_irq_o(irq),
        .spr_rd_valid_o(rd_valid), .spr_rd_data_o(rd_data), .miss_threshold_o(thr),
        .first_event_counter_o(cnt1), .second_event_counter_o(cnt2));

    task close_out;
        if (n_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Pulses counted before the edge lands; cap guards against a hang
    always @(posedge sys_clk)
    begin
        cycles++;
        if (irq === 1'b1)
            n_irq++;
        if (cycles == 20000)
        begin
            n_errors++;
            $display("unexpected at %0t: run too long", $time);
            close_out();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task chk_n(input int got, input int exp);
        n_tests++;
        if (got != exp)
        begin
            n_errors++;
            $display("unexpected at %0t: %0d pulses, want %0d", $time, got, exp);
        end
    endtask

    // One register move: request held for exactly one taking edge
    task spr(input logic w, input logic [9:0] n, input logic [31:0] d);
        @(negedge sys_clk);
        req.rd = ~w;
        req.wr = w;
        req.num = n;
        req.data = d;
        @(negedge sys_clk);
        req.rd = 1'b0;
        req.wr = 1'b0;
    endtask

    task rd_chk(input logic [9:0] n, input logic [31:0] exp);
        spr(1'b0, n, 32'h0);
        chk({31'h0, rd_valid}, 32'h1);
        chk(rd_data, exp);
    endtask

    task run_ev(input logic [4:0] sel, input logic [1:0] o, input int k);
        @(negedge sys_clk);
        ev_sel = sel;
        occ = o;
        run = 1'b1;
        repeat (k) @(negedge sys_clk);
        run = 1'b0;
    endtask

    task t_regs;
        rd_chk(10'h3b8, 32'h0);
        rd_chk(10'h3c0, 32'h0);
        rd_chk(10'h3c1, 32'h0);
        spr(1'b1, 10'h3b8, 32'hffff_ffff);
        rd_chk(10'h3b8, 32'hffff_ffff);
        chk({26'h0, thr}, 32'h3f);
        spr(1'b1, 10'h123, 32'h0);
        rd_chk(10'h3b8, 32'hffff_ffff);
        rd_chk(10'h123, 32'h0);
        spr(1'b1, 10'h3b8, 32'h0);
        spr(1'b1, 10'h3c0, 32'h1234_5678);
        spr(1'b1, 10'h3c1, 32'h0bad_cafe);
        rd_chk(10'h3c0, 32'h1234_5678);
        chk(cnt2, 32'h0bad_cafe);
        // Both selectors all ones: reserved upper bits must not move the pick off event 31
        spr(1'b1, 10'h3b8, 32'h0000_1fff);
        run_ev(5'h1f, 2'h3, 3);
        chk(cnt1, 32'h1234_5681);
        chk(cnt2, 32'h0bad_cb07);
    endtask

    task t_halt;
        logic [31:0] b1;
        logic [31:0] b2;
        logic en;
        for (int h = 0; h < 32; h++)
        begin
            for (int s = 0; s < 4; s++)
            begin
                spr(1'b1, 10'h3b8, {h[4:0], 27'h0});
                user = s[1];
                marked = s[0];
                b1 = cnt1;
                b2 = cnt2;
                run_ev(5'h0, 2'h1, 2);
                en = !(h[4] | h[3] & !s[1] | h[2] & s[1] | h[1] & s[0] | h[0] & !s[0]);
                chk(cnt1, b1 + (en ? 32'h2 : 32'h0));
                chk(cnt2, b2 + (en ? 32'h2 : 32'h0));
            end
        end
        user = 1'b0;
        marked = 1'b0;
    endtask

    task neg_case(input logic [31:0] ctl, input logic [31:0] c1, input logic [31:0] c2,
                  input int exp_irq, input logic [31:0] e1, input logic [31:0] e2);
        spr(1'b1, 10'h3b8, 32'h0);
        spr(1'b1, 10'h3c0, c1);
        spr(1'b1, 10'h3c1, c2);
        spr(1'b1, 10'h3b8, ctl);
        n_irq = 0;
        run_ev(5'h1, 2'h1, 3);
        repeat (3) @(negedge sys_clk);
        chk_n(n_irq, exp_irq);
        chk(cnt1, e1);
        chk(cnt2, e2);
        rd_chk(10'h3b8, ctl & ~(exp_irq != 0 ? 32'h0400_0000 : 32'h0));
    endtask

    task t_neg;
        neg_case(32'h0600_8040, 32'h7fff_ffff, 32'h0, 1, 32'h8000_0000, 32'h0);
        neg_case(32'h0600_0040, 32'h7fff_ffff, 32'h0, 0, 32'h8000_0002, 32'h0);
        neg_case(32'h0600_4001, 32'h0, 32'h7fff_ffff, 1, 32'h0, 32'h8000_0002);
        neg_case(32'h0600_8041, 32'h7fff_ffff, 32'h0, 1, 32'h8000_0000, 32'h1);
    endtask

    // Wrong picks rise first, so only the selected bit may fire
    task tb_case(input logic [1:0] c, input logic en, input int exp);
        logic [63:0] mask;
        int pick [4];
        pick = '{0, 8, 12, 16};
        mask = 64'h1_1101;
        tb = 64'h0;
        spr(1'b1, 10'h3b8, {5'h0, 1'b1, 1'b0, c, en, 22'h0});
        repeat (2) @(negedge sys_clk);
        n_irq = 0;
        tb = mask & ~(64'h1 << pick[c]);
        repeat (4) @(negedge sys_clk);
        chk_n(n_irq, 0);
        tb = mask;
        repeat (4) @(negedge sys_clk);
        chk_n(n_irq, exp);
        rd_chk(10'h3b8, {5'h0, exp == 0, 1'b0, c, en, 22'h0});
    endtask

    task t_tb;
        for (int c = 0; c < 4; c++)
            tb_case(c[1:0], 1'b1, 1);
        tb_case(2'h0, 1'b0, 0);
    endtask

    task t_trig;
        spr(1'b1, 10'h3b8, 32'h0);
        spr(1'b1, 10'h3c0, 32'h7fff_fffe);
        spr(1'b1, 10'h3c1, 32'h0);
        spr(1'b1, 10'h3b8, 32'h0000_2041);
        run_ev(5'h1, 2'h1, 4);
        chk(cnt1, 32'h8000_0002);
        chk(cnt2, 32'h2);
    endtask

    initial
    begin
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        t_regs();
        t_halt();
        t_neg();
        t_tb();
        t_trig();
        close_out();
    end
endmodule
`default_nettype wire
